// *** pic8_regs.vh ***
`ifndef PIC8_REGS_VH
`define PIC8_REGS_VH

// ------------------------------------------------------------
// Port offsets inside the strap-selected group of four
// ------------------------------------------------------------
`define PIC8_PORT_CLEAR 2'd0
`define PIC8_PORT_MASK 2'd1
`define PIC8_PORT_CTRL 2'd2
`define PIC8_PORT_LATCH 2'd0
`define PIC8_PORT_RESP 2'd1
`define PIC8_PORT_STATUS 2'd2
`define PIC8_PORT_CODE 2'd3

// ------------------------------------------------------------
// Extra registers, selected by address bit 10
// ------------------------------------------------------------
`define PIC8_XREG_BIT 10
`define PIC8_X_EVT_STAT 2'd0
`define PIC8_X_EVT_MASK 2'd1
`define PIC8_X_TBL_ADDR 2'd2
`define PIC8_X_TBL_DATA 2'd3

// ------------------------------------------------------------
// Control port fields and reset values
// ------------------------------------------------------------
`define PIC8_CTRL_CARD_EN 0
`define PIC8_CTRL_PASS_EN 1
`define PIC8_CTRL_CHAIN_RST 2
`define PIC8_CTRL_POLL_EN 3
`define PIC8_CTRL_AUTOCLR 4
`define PIC8_CTRL_RESET 5'h13
`define PIC8_MASK_RESET 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
// Cycles after reset before strap levels have passed the pin filter
`define PIC8_STRAP_SETTLE 3'd4

// ------------------------------------------------------------
// Event bits
// ------------------------------------------------------------
`define PIC8_EVT_LATCHED 0
`define PIC8_EVT_ACKED 1
`define PIC8_EVT_POLLED 2

// Single-byte call instruction: 11 nnn 111
`define PIC8_CALL_BASE 8'hc7

`endif

// *** pic8_pin_in.v ***
`timescale 1ns/1ns
module pic8_pin_in #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] pin_i,
    output wire [W-1:0] level_o,
    output wire [W-1:0] fall_o
);

// ------------------------------------------------------------
// Two-flop synchroniser, then a two-sample agreement filter
// ------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
        reg s1_reg;
        reg s2_reg;
        reg s3_reg;
        reg filt_reg;
        wire filt_next;
        assign filt_next = (s2_reg == s3_reg) ? s3_reg : filt_reg;
        always @(posedge clk_i) begin
            if (rst_i) begin
                s1_reg <= 1'b1;
                s2_reg <= 1'b1;
                s3_reg <= 1'b1;
                filt_reg <= 1'b1;
            end else begin
                s1_reg <= pin_i[g];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                filt_reg <= filt_next;
            end
        end
        assign level_o[g] = filt_reg;
        // Only a high-to-low change of the filtered level counts
        assign fall_o[g] = filt_reg & ~filt_next;
    end
endgenerate

endmodule

// *** pic8_ctrl.v ***
`timescale 1ns/1ns
`include "pic8_regs.vh"
// How it works
// [R1] Each request latch is set only by a filtered falling edge on its pin.
// [R2] Software reads, masks and clears every request latch through ports.
// [R3] Request 0 has the highest fixed priority and request 7 the lowest.
// [R4] An acknowledge gets a single byte on the data bus, else ports poll.
// [R5] By default the byte is a call instruction chosen by the winner.
// [R6] Optionally a loaded 32x8 table supplies the byte instead, never both.
// [R7] The card joins a priority chain with one chain input and one output.
// [R8] Passing priority on is gated by hardware state and software bits.
// [R9] Three output ports and the input ports are decoded in the port space.
// [R10] In poll mode a second input port returns the acknowledge byte.
// [R11] The base port address is chosen by strap inputs caught after reset.
// [R12] A cleared mask bit blocks a latch from interrupting, nothing more.
// [R13] The answered latch is cleared by the acknowledge, all by reset.
// [R14] Interrupts need the chain input; the chain output holds until reset or a control write with chain reset set.
// [R15] Acknowledge or port read freezes request output and chain state.
// [R16] Request is raised by any pending unmasked latch with chain input and card enable on.
// [R17] The data bus is driven only during an acknowledge cycle.
module pic8_ctrl #(
    parameter USE_TABLE = 0
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [7:0] irq_request_in_n_i,
    output reg [7:0] request_seen_out_n_o,
    input wire int_ack_n_i,
    input wire freeze_n_i,
    input wire chain_in_i,
    output reg chain_priority_out_o,
    output reg int_req_n_o,
    output reg [7:0] ack_data_o,
    output reg ack_data_oe_o,
    input wire [3:0] addr_strap_high_i,
    input wire [1:0] addr_strap_low_i,
    input wire [1:0] table_group_i,
    output reg irq_o
);

// ------------------------------------------------------------
// Pin inputs
// ------------------------------------------------------------
wire [18:0] pin_level;
wire [18:0] pin_fall;
pic8_pin_in #(.W(19)) u_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({table_group_i, addr_strap_low_i, addr_strap_high_i,
            chain_in_i, freeze_n_i, int_ack_n_i, irq_request_in_n_i}),
    .level_o(pin_level),
    .fall_o(pin_fall)
);
wire [7:0] req_fall = pin_fall[7:0];
wire ack_act = ~pin_level[8];
wire freeze_pin = ~pin_level[9];
wire chain_in = pin_level[10];

// ------------------------------------------------------------
// Strap capture
// ------------------------------------------------------------
reg strap_done_reg;
reg [2:0] settle_reg;
reg [5:0] base_reg;
reg [1:0] group_reg;
// Pin filters restart from their preset after reset, so wait for them
always @(posedge clk_i) begin
    if (rst_i) begin
        strap_done_reg <= 1'b0;
        settle_reg <= 3'd0;
        base_reg <= 6'h00;
        group_reg <= 2'b00;
    end else if (!strap_done_reg) begin
        if (settle_reg == `PIC8_STRAP_SETTLE) begin
            strap_done_reg <= 1'b1;
            base_reg <= {pin_level[14:11], pin_level[16:15]}; // [R11]
            group_reg <= pin_level[18:17];
        end else begin
            settle_reg <= settle_reg + 3'd1;
        end
    end
end

// ------------------------------------------------------------
// Bus decode
// ------------------------------------------------------------
wire wb_req = wb_cyc_i & wb_stb_i;
wire wb_take = wb_req & ~wb_ack_o;
wire is_xreg = wb_adr_i[`PIC8_XREG_BIT];
wire [7:0] port_num = wb_adr_i[9:2];
wire in_ports = strap_done_reg & ~is_xreg &
    (port_num[7:2] == base_reg); // [R9]
wire [1:0] sub = wb_adr_i[3:2];
wire wr_ok = wb_take & wb_we_i & wb_sel_i[0];
wire port_wr = wr_ok & in_ports;
wire port_rd = wb_take & ~wb_we_i & in_ports;
wire x_wr = wr_ok & is_xreg & (wb_adr_i[9:4] == 6'h00);

// ------------------------------------------------------------
// Registers and state
// ------------------------------------------------------------
reg [7:0] latch_reg;
reg [7:0] mask_reg;
reg [4:0] ctrl_reg;
reg hold_reg;
reg [7:0] resp_reg;
reg [2:0] idx_reg;
reg valid_reg;
reg ack_prev_reg;
reg [2:0] evt_stat_reg;
reg [2:0] evt_mask_reg;
reg [4:0] tbl_addr_reg;
reg [7:0] table_mem [0:31];

// ------------------------------------------------------------
// Priority and response
// ------------------------------------------------------------
wire [7:0] pending = latch_reg & mask_reg; // [R12]
wire card_on = chain_in & ctrl_reg[`PIC8_CTRL_CARD_EN];
wire req_any = (|pending) & card_on; // [R16]
reg [2:0] win_idx;
integer k;
always @* begin
    win_idx = 3'd0;
    for (k = 7; k >= 0; k = k - 1) begin
        if (pending[k]) begin
            win_idx = k[2:0]; // [R3]
        end
    end
end
wire [7:0] call_byte = `PIC8_CALL_BASE | {2'b00, win_idx, 3'b000}; // [R5]
wire [7:0] table_byte = table_mem[{group_reg, win_idx}];
wire [7:0] resp_byte = (USE_TABLE != 0) ? table_byte : call_byte; // [R6]

// Freeze while the response is being read in any way
wire freeze = ack_act | freeze_pin | (wb_req & in_ports & ~wb_we_i);

always @(posedge clk_i) begin
    if (rst_i) begin
        resp_reg <= `PIC8_CALL_BASE;
        idx_reg <= 3'd0;
        valid_reg <= 1'b0;
        int_req_n_o <= 1'b1;
        chain_priority_out_o <= 1'b0;
    end else if (!freeze) begin // [R15]
        resp_reg <= resp_byte;
        idx_reg <= win_idx;
        valid_reg <= req_any;
        int_req_n_o <= ~req_any; // [R14]
        chain_priority_out_o <= chain_in & ~req_any & ~hold_reg &
            ctrl_reg[`PIC8_CTRL_PASS_EN]; // [R7] [R8]
    end
end

// ------------------------------------------------------------
// Acknowledge cycle
// ------------------------------------------------------------
wire ack_end = ack_prev_reg & ~ack_act;
wire autoclr = ctrl_reg[`PIC8_CTRL_AUTOCLR];
wire poll_rd = port_rd & (sub == `PIC8_PORT_RESP) &
    ctrl_reg[`PIC8_CTRL_POLL_EN];
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_prev_reg <= 1'b0;
        ack_data_o <= 8'h00;
        ack_data_oe_o <= 1'b0;
    end else begin
        ack_prev_reg <= ack_act;
        ack_data_oe_o <= ack_act; // [R17]
        ack_data_o <= ack_act ? resp_reg : 8'h00; // [R4]
    end
end

// ------------------------------------------------------------
// Request latches and control ports
// ------------------------------------------------------------
reg [7:0] clr_vec;
reg [7:0] latch_next;
always @* begin
    clr_vec = 8'h00;
    if (port_wr && sub == `PIC8_PORT_CLEAR) begin
        clr_vec = wb_dat_i[7:0]; // [R2]
    end
    if (valid_reg && autoclr && (ack_end || poll_rd)) begin
        clr_vec[idx_reg] = 1'b1; // [R13]
    end
    latch_next = (latch_reg & ~clr_vec) | req_fall; // [R1]
end

always @(posedge clk_i) begin
    if (rst_i) begin
        latch_reg <= 8'h00; // [R13]
        request_seen_out_n_o <= 8'hff;
        mask_reg <= `PIC8_MASK_RESET;
        ctrl_reg <= `PIC8_CTRL_RESET;
        hold_reg <= 1'b0;
    end else begin
        latch_reg <= latch_next;
        request_seen_out_n_o <= ~latch_next;
        if (port_wr && sub == `PIC8_PORT_MASK) begin
            mask_reg <= wb_dat_i[7:0]; // [R2]
        end
        if (port_wr && sub == `PIC8_PORT_CTRL) begin
            ctrl_reg <= {wb_dat_i[4:3], 1'b0, wb_dat_i[1:0]}; // [R8]
        end
        if (!freeze && req_any) begin
            hold_reg <= 1'b1; // [R14]
        end else if (port_wr && sub == `PIC8_PORT_CTRL &&
                     wb_dat_i[`PIC8_CTRL_CHAIN_RST]) begin
            hold_reg <= 1'b0; // [R14]
        end
    end
end

// ------------------------------------------------------------
// Response table loading
// ------------------------------------------------------------
always @(posedge clk_i) begin
    if (x_wr && sub == `PIC8_X_TBL_DATA) begin
        table_mem[tbl_addr_reg] <= wb_dat_i[7:0]; // [R6]
    end
end

// ------------------------------------------------------------
// Events and interrupt line
// ------------------------------------------------------------
wire [2:0] evt_set = {poll_rd & valid_reg, ack_end, |req_fall};
reg [2:0] evt_clr;
always @* begin
    evt_clr = 3'b000;
    if (x_wr && sub == `PIC8_X_EVT_STAT) begin
        evt_clr = wb_dat_i[2:0];
    end
end
always @(posedge clk_i) begin
    if (rst_i) begin
        evt_stat_reg <= 3'b000;
        evt_mask_reg <= 3'b000;
        tbl_addr_reg <= 5'd0;
        irq_o <= 1'b0;
    end else begin
        evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
        irq_o <= |(((evt_stat_reg & ~evt_clr) | evt_set) & evt_mask_reg);
        if (x_wr && sub == `PIC8_X_EVT_MASK) begin
            evt_mask_reg <= wb_dat_i[2:0];
        end
        if (x_wr && sub == `PIC8_X_TBL_ADDR) begin
            tbl_addr_reg <= wb_dat_i[4:0];
        end else if (x_wr && sub == `PIC8_X_TBL_DATA) begin
            tbl_addr_reg <= tbl_addr_reg + 5'd1;
        end
    end
end

// ------------------------------------------------------------
// Bus read data and acknowledge
// ------------------------------------------------------------
reg [31:0] rd_data;
always @* begin
    rd_data = 32'h00000000;
    if (in_ports) begin
        case (sub)
            `PIC8_PORT_LATCH: rd_data = {24'h000000, latch_reg};
            `PIC8_PORT_RESP: begin
                if (ctrl_reg[`PIC8_CTRL_POLL_EN]) begin
                    rd_data = {24'h000000, resp_reg}; // [R10]
                end
            end
            `PIC8_PORT_STATUS: rd_data = {24'h000000, chain_in, valid_reg,
                hold_reg, ctrl_reg};
            `PIC8_PORT_CODE: rd_data = {24'h000000, valid_reg, 4'h0,
                idx_reg};
            default: rd_data = 32'h00000000;
        endcase
    end else if (is_xreg && wb_adr_i[9:4] == 6'h00) begin
        case (sub)
            `PIC8_X_EVT_STAT: rd_data = {29'h00000000, evt_stat_reg};
            `PIC8_X_EVT_MASK: rd_data = {29'h00000000, evt_mask_reg};
            `PIC8_X_TBL_ADDR: rd_data = {27'h0000000, tbl_addr_reg};
            `PIC8_X_TBL_DATA: rd_data = {24'h000000,
                table_mem[tbl_addr_reg]};
            default: rd_data = 32'h00000000;
        endcase
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= wb_take;
        wb_dat_o <= wb_take ? rd_data : 32'h00000000;
    end
end

endmodule

// *** pic8_properties.sv ***
`timescale 1ns/1ns
module pic8_properties #(
    parameter USE_TABLE = 0
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire int_ack_n_i,
    input wire chain_priority_out_o,
    input wire int_req_n_o,
    input wire [7:0] ack_data_o,
    input wire ack_data_oe_o,
    input wire [7:0] request_seen_out_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    bus_take_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    ack_once_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    byte_idle_a: assert property (
        !ack_data_oe_o |-> ack_data_o == 8'h00)
        else $error("byte driven outside ack");
    ack_cause_a: assert property (
        $rose(ack_data_oe_o) |-> !$past(int_ack_n_i))
        else $error("byte driven without ack");
    byte_hold_a: assert property (
        ack_data_oe_o && $past(ack_data_oe_o) |-> $stable(ack_data_o))
        else $error("byte changed during ack");
    call_form_a: assert property (
        ack_data_oe_o && USE_TABLE == 0 |-> (ack_data_o & 8'hc7) == 8'hc7)
        else $error("byte is not a call");
    req_cause_a: assert property (
        $fell(int_req_n_o) |-> request_seen_out_n_o != 8'hff)
        else $error("request without latch");
    chain_block_a: assert property (
        !int_req_n_o |-> !chain_priority_out_o)
        else $error("chain passed while requesting");
endmodule

bind pic8_ctrl pic8_properties #(.USE_TABLE(USE_TABLE)) u_props (.*);

// *** pic8_cpu_model.sv ***
`timescale 1ns/1ns
module pic8_cpu_model (
    input wire clk_i,
    input wire rst_i,
    input wire en_i,
    input wire [3:0] wait_i,
    input wire int_req_n_i,
    input wire [7:0] ack_data_i,
    input wire ack_data_oe_i,
    output logic int_ack_n_o,
    output logic got_o,
    output logic [7:0] byte_o
);
    logic [4:0] cnt_reg;
    always @(posedge clk_i) begin
        got_o <= 1'b0;
        if (rst_i) begin
            int_ack_n_o <= 1'b1;
            cnt_reg <= 5'd0;
        end else if (int_ack_n_o) begin
            // Settle time so a stale request is not answered twice
            cnt_reg <= (ack_data_oe_i || int_req_n_i || !en_i) ? 5'd0 :
                cnt_reg + 5'd1;
            if (cnt_reg == {1'b0, wait_i} + 5'd8) begin
                int_ack_n_o <= 1'b0;
                cnt_reg <= 5'd0;
            end
        end else if (ack_data_oe_i) begin
            cnt_reg <= cnt_reg + 5'd1;
            if (cnt_reg == 5'd3) begin
                byte_o <= ack_data_i;
                got_o <= 1'b1;
                int_ack_n_o <= 1'b1;
                cnt_reg <= 5'd0;
            end
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0, stb = 0, we = 0, chain_in = 1, cpu_en = 0;
    logic [3:0] sel = 4'h0, sh, wt = 4'h0;
    logic [1:0] sl;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [7:0] pins = 8'hff, p;
    wire [31:0] rdat;
    wire [7:0] abus, seen_n, abyte;
    wire ack, ack_n, chain_out, req_n, oe, irq, got;
    logic [31:0] rq[$];
    logic [7:0] aq[$];
    int err_count = 0, n_compared = 0, n, k, idx;

    always #5 clk_i = ~clk_i;

    pic8_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_request_in_n_i(pins), .request_seen_out_n_o(seen_n),
        .int_ack_n_i(ack_n), .freeze_n_i(1'b1), .chain_in_i(chain_in),
        .chain_priority_out_o(chain_out), .int_req_n_o(req_n),
        .ack_data_o(abus), .ack_data_oe_o(oe), .addr_strap_high_i(sh),
        .addr_strap_low_i(sl), .table_group_i(2'b00), .irq_o(irq));
    pic8_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .en_i(cpu_en),
        .wait_i(wt), .int_req_n_i(req_n), .ack_data_i(abus),
        .ack_data_oe_i(oe), .int_ack_n_o(ack_n), .got_o(got),
        .byte_o(abyte));

    task end_sim;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_count++;
            end_sim;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task pulse(input logic [7:0] m);
        pins <= ~m;
        repeat (4) @(posedge clk_i);
        pins <= 8'hff;
        repeat (8) @(posedge clk_i);
    endtask

    function logic [11:0] pa(input logic [1:0] o);
        return {2'b00, sh, sl, o, 2'b00};
    endfunction

    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0)
            chk("read data", rq.pop_front(), rdat);
        if (got === 1'b1)
            chk("ack byte", {24'h0, aq.pop_front()}, {24'h0, abyte});
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        err_count++;
        end_sim;
    end

    initial begin
        void'($urandom(31023));
        sh <= 4'($urandom);
        sl <= 2'($urandom);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Straps must pass the pin filters before they are caught
        repeat (8) @(posedge clk_i);
        rd(pa(2'd0), 32'h0);
        rd(pa(2'd2), 32'h93);
        rd({2'b00, ~sh, sl, 4'h0}, 32'h0);
        $display("test reset done");
        p = 8'($urandom) | 8'h20;
        idx = 8;
        for (int i = 7; i >= 0; i--)
            if (p[i])
                idx = i;
        wb(1'b1, 12'h404, 32'h1);
        pulse(p);
        chk("request", 32'h1, {31'h0, req_n});
        chk("seen", {24'h0, ~p}, {24'h0, seen_n});
        rd(pa(2'd0), {24'h0, p});
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, 12'h400, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wb(1'b1, pa(2'd1), 32'hff);
        rd(pa(2'd3), {24'h0, 5'h10, idx[2:0]});
        for (int i = 0; i < 8; i++)
            if (p[i])
                aq.push_back(8'hc7 | 8'(i << 3));
        wt <= 4'($urandom);
        cpu_en <= 1'b1;
        n = 0;
        while (seen_n !== 8'hff && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) begin
            err_count++;
            end_sim;
        end
        repeat (20) @(posedge clk_i);
        cpu_en <= 1'b0;
        chk("latches", 32'h0, {24'h0, ~seen_n});
        chk("acks left", 32'h0, aq.size());
        chk("chain", 32'h0, {31'h0, chain_out});
        wb(1'b1, pa(2'd2), 32'h17);
        repeat (4) @(posedge clk_i);
        chk("chain", 32'h1, {31'h0, chain_out});
        wb(1'b1, pa(2'd2), 32'h11);
        repeat (2) @(posedge clk_i);
        chk("chain", 32'h0, {31'h0, chain_out});
        $display("test acknowledge done");
        wb(1'b1, pa(2'd2), 32'h19);
        chain_in <= 1'b0;
        k = $urandom % 8;
        pulse(8'h1 << k);
        chk("request", 32'h1, {31'h0, req_n});
        chain_in <= 1'b1;
        // Chain input passes the pin filter before the request is valid
        repeat (8) @(posedge clk_i);
        rd(pa(2'd1), 32'hc7 | (k << 3));
        rd(pa(2'd0), 32'h0);
        pulse(8'hff);
        wb(1'b1, pa(2'd0), 32'h0f);
        rd(pa(2'd0), 32'hf0);
        rd(12'h400, 32'h7);
        idx = $urandom % 256;
        wb(1'b1, 12'h408, 32'h1e);
        wb(1'b1, 12'h40c, idx);
        rd(12'h408, 32'h1f);
        wb(1'b1, 12'h408, 32'h1e);
        rd(12'h40c, idx);
        $display("test poll done");
        end_sim;
    end
endmodule
